// File: bench/tb.sv
// Testbench of the reset controller: power-on, watchdog and pin resets,
// reset values over AXI4-Lite, STOP entry and the SE0 wake block.
// Assumes the vector memory model and a shortened stabilization count.
`timescale 1ns/100ps
`default_nettype none
module tb
  import mcu_reset_pkg::*;
;
  localparam int          STAB   = 16;
  localparam logic [15:0] PC_EXP = 16'hc35a;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_reset_n = 1'b1;
  logic wdt_overflow = 1'b0;
  logic stop_request = 1'b0;
  logic ext_wake = 1'b0;
  logic usb_reset_resume_irq = 1'b0;
  logic usb_minus_line = 1'b0;
  logic usb_plus_line = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic [7:0]  vector_data, port_out_latch, port_direction;
  logic [15:0] vector_addr, program_counter;
  logic pc_valid, cpu_run, cpu_stopped, pins_drive_en;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [31:0] seed = 32'h47;
  logic [4:0]  idx;
  int miscompares = 0, checked = 0, hz_bad = 0, n;

  always #5 core_clk = ~core_clk;

  mcu_reset_controller #(.STAB_CYCLES(STAB)) mcu_reset_controller_i (
    .core_clk, .rst_n, .ext_reset_n, .wdt_overflow, .stop_request, .ext_wake,
    .usb_reset_resume_irq, .usb_minus_line, .usb_plus_line, .vector_data,
    .vector_addr, .program_counter, .pc_valid, .cpu_run, .cpu_stopped,
    .pins_drive_en, .port_out_latch, .port_direction, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  vector_rom vector_rom_i (.core_clk, .vector_addr, .vector_data);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] exp_init(input logic [4:0] i);
    case (i)
      5'h00, 5'h05: return 8'h02;
      5'h02, 5'h0e: return 8'hff;
      5'h06: return 8'h04;
      5'h11: return 8'h18;
      5'h12: return 8'h20;
      5'h13: return 8'h30;
      5'h14: return 8'h01;
      5'h15: return 8'h08;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // 0 stop, 1 usb event, 2 watchdog overflow
  task automatic pulse(input int w);
    @(posedge core_clk);
    if (w == 0) stop_request <= 1'b1;
    else if (w == 1) usb_reset_resume_irq <= 1'b1;
    else wdt_overflow <= 1'b1;
    @(posedge core_clk);
    stop_request <= 1'b0;
    usb_reset_resume_irq <= 1'b0;
    wdt_overflow <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] v, output logic [1:0] rs);
    logic got;
    got = 1'b0;
    @(posedge core_clk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h000000, v};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rs = bresp;
        bready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [4:0] i, output logic [31:0] v, output logic [1:0] rs);
    logic got;
    got = 1'b0;
    @(posedge core_clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask
  task automatic check_all();
    for (int i = 0; i < 27; i++) begin
      rd(i[4:0], d, r);
      chk("reset_value", {24'h000000, exp_init(i[4:0])}, d);
    end
  endtask
  // Pins drop on the same edge that enters reset; the first sample is skipped anyway
  task automatic wait_run();
    n = 0;
    while (pc_valid !== 1'b0 && n < 10) begin
      @(posedge core_clk);
      n++;
    end
    n = 0;
    while (pc_valid !== 1'b1 && n < 300) begin
      if (pins_drive_en !== 1'b0 && n > 0) hz_bad++;
      @(posedge core_clk);
      n++;
    end
    chk("wait_len", 32'h1, (n >= STAB && n <= STAB + 8));
    chk("pins_hiz", 32'h0, hz_bad);
    chk("pc", PC_EXP, program_counter);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // All tests need well under 3000 cycles
  initial begin
    #100000;
    miscompares++;
    test_done();
  end

  initial begin
    tick(3);
    rst_n <= 1'b1;
    wait_run();
    tick(2);
    chk("pins_drive", 32'h1, pins_drive_en);
    chk("direction", 32'hff, port_direction);
    chk("latch", 32'h0, port_out_latch);
    check_all();
    $display("test power_on done");
    repeat (12) begin
      seed = xs(seed);
      idx = 5'(seed[7:0] % 8'h1b);
      if (idx == IDX_IRQ_REQ) idx = 5'h0c;
      wr(idx, seed[15:8], r);
      chk("wr_resp", RESP_OKAY, r);
      rd(idx, d, r);
      chk("readback", {24'h000000, seed[15:8]}, d);
    end
    pulse(2);
    wait_run();
    rd(IDX_STAT, d, r);
    chk("wdt_cause", 32'h1, d[ST_WDT_BIT]);
    chk("run_state", 32'h4, d[2:0]);
    check_all();
    $display("test watchdog done");
    wr(5'h1d, 8'h55, r);
    chk("bad_wr", RESP_SLVERR, r);
    rd(5'h1d, d, r);
    chk("bad_rd", RESP_SLVERR, r);
    chk("bad_rdata", 32'h0, d);
    $display("test refuse done");
    wr(IDX_IRQ_MASK, 8'hfe, r);
    pulse(0);
    tick(3);
    chk("stopped", 32'h1, cpu_stopped);
    chk("run_off", 32'h0, cpu_run);
    pulse(1);
    n = 0;
    while (cpu_stopped !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    chk("usb_wake", 32'h0, cpu_stopped);
    wr(IDX_IRQ_REQ, 8'h00, r);
    chk("run_on", 32'h1, cpu_run);
    $display("test stop_wake done");
    usb_plus_line <= 1'b0;
    pulse(0);
    tick(3);
    rd(IDX_STAT, d, r);
    chk("se0_mark", 32'h1, d[ST_SE0_BIT]);
    pulse(1);
    tick(220);
    chk("se0_blocks", 32'h1, cpu_stopped);
    ext_reset_n <= 1'b0;
    tick(6);
    chk("stop_held", 32'h1, cpu_stopped);
    chk("pins_float", 32'h0, pins_drive_en);
    chk("pc_invalid", 32'h0, pc_valid);
    ext_reset_n <= 1'b1;
    usb_plus_line <= 1'b1;
    wait_run();
    chk("stop_cleared", 32'h0, cpu_stopped);
    check_all();
    $display("test stop_se0_reset done");
    test_done();
  end
endmodule
`default_nettype wire

// File: bench/vector_rom.sv
// Vector memory model: a synchronous byte memory, data one cycle after address.
// Assumes the controller reads only the two vector bytes.
`timescale 1ns/100ps
`default_nettype none
module vector_rom #(
  parameter logic [7:0] LO_BYTE = 8'h5a,
  parameter logic [7:0] HI_BYTE = 8'hc3
) (
  input  wire logic [15:0] vector_addr,
  input  wire logic        core_clk,
  output logic      [7:0]  vector_data
);
  initial vector_data = 8'h00;
  // Off-vector reads toggle so a stale byte never passes for a vector
  always @(posedge core_clk) begin
    if (vector_addr == 16'h0000) vector_data <= LO_BYTE;
    else if (vector_addr == 16'h0001) vector_data <= HI_BYTE;
    else vector_data <= ~vector_data;
  end
endmodule
`default_nettype wire

// File: design/level_sync.sv
// Two-flop synchroniser for the external reset pin.
// Assumes the pin is asynchronous to core_clk; resets to the asserted level.
`timescale 1ns/100ps
`default_nettype none
module level_sync
  import mcu_reset_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// File: design/mcu_reset_controller.sv
// Reset controller: pin and watchdog reset, stabilization wait, vector fetch,
// reset values of the core registers, STOP hold and SE0 wake blocking.
// Assumes a synchronous byte memory for the vector and an AXI4-Lite master.
// Notes on behaviour
// - Pin low or watchdog overflow resets identically
// - PC loads from vector bytes 0000H/0001H
// - Pins high impedance during reset and wait
// - Pin release, then wait 2^15 clocks
// - Watchdog reset releases itself, same wait
// - Reset keeps STOP held; pins still float
// - PC undefined in reset; others defined
// - SP, RAM, compare, shift, USB banks uninitialized
// - Status word resets to 02H
// - Port latches, pull-ups, modes 00H; direction FFH
// - Clock control 02H, stabilization select 04H
// - Timers, modes, watchdog registers reset 00H
// - Request flags 00H, masks FFH, modes 00H
// - USB byte counters reset 18H, 20H, 30H
// - USB start 01H, wakeup 08H, others 00H
// - STOP entered in SE0 ignores USB wake
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
module mcu_reset_controller
  import mcu_reset_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = STAB_CYCLES_DEF
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              ext_reset_n,
  input  wire logic              wdt_overflow,
  input  wire logic              stop_request,
  input  wire logic              ext_wake,
  input  wire logic              usb_reset_resume_irq,
  input  wire logic              usb_minus_line,
  input  wire logic              usb_plus_line,
  input  wire logic [7:0]        vector_data,
  output logic      [15:0]       vector_addr,
  output logic      [15:0]       program_counter,
  output logic                   pc_valid,
  output logic                   cpu_run,
  output logic                   cpu_stopped,
  output logic                   pins_drive_en,
  output logic      [7:0]        port_out_latch,
  output logic      [7:0]        port_direction,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready
);
  rst_state_t        state;
  rst_state_t        next_state;
  logic              pin_n_sync;
  logic [STAB_W-1:0] stab_count;
  logic [7:0]        regs [NREG];
  logic [7:0]        cmp_reg;
  logic              wdt_cause;
  logic              se0_at_stop;
  logic              aw_held;
  logic              w_held;
  logic [4:0]        aw_idx;
  logic [7:0]        w_byte;
  logic              w_lane;

  function automatic logic idx_ok(input logic [4:0] idx);
    return idx <= IDX_STAT;
  endfunction

  function automatic logic idx_rw(input logic [4:0] idx);
    return idx < IDX_STAT;
  endfunction

  level_sync u_pin_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (ext_reset_n),
    .sync_out (pin_n_sync)
  );

  wire       reset_in   = !pin_n_sync || wdt_overflow;
  wire       in_reset   = (state == ST_HOLD) || (state == ST_WAIT);
  wire       stab_done  = stab_count == STAB_W'(STAB_CYCLES - 1);
  wire       usb_se0    = !usb_minus_line && !usb_plus_line;
  wire       usb_mask   = regs[IDX_IRQ_MASK][USB_RR_BIT];
  wire       usb_wake   = usb_reset_resume_irq && !usb_mask && !se0_at_stop;
  wire       wake       = ext_wake || usb_wake;
  wire       stop_entry = (state == ST_RUN) && stop_request && !cpu_stopped;
  wire       fetch_start = (state == ST_WAIT) && (next_state == ST_VEC_LO);
  wire       wr_fire    = aw_held && w_held && !bvalid;
  wire [4:0] ar_idx     = araddr[ADDR_W-1:2];
  wire [7:0] status_val = {2'b00, se0_at_stop, cpu_stopped, wdt_cause, state};
  wire [7:0] rd_byte    = (ar_idx == IDX_STAT) ? status_val :
                          (ar_idx == IDX_CMP)  ? cmp_reg    :
                          idx_rw(ar_idx)       ? regs[ar_idx] : 8'h00;

  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD:   if (!reset_in) next_state = ST_WAIT;
      ST_WAIT:   if (stab_done) next_state = ST_VEC_LO;
      ST_VEC_LO: next_state = ST_VEC_HI;
      ST_VEC_HI: next_state = ST_RUN;
      ST_RUN:    next_state = ST_RUN;
      default:   next_state = ST_HOLD;
    endcase
    if (reset_in) next_state = ST_HOLD;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) state <= ST_HOLD;
    else        state <= next_state;
  end

  // Counts only inside the wait; restarts whenever reset is reapplied
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)                 stab_count <= '0;
    else if (state != ST_WAIT)  stab_count <= '0;
    else if (!stab_done)        stab_count <= stab_count + 1'b1;
  end

  // Vector bytes arrive one cycle after their address
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_addr     <= VEC_LO_ADDR;
      program_counter <= '0;
      pc_valid        <= 1'b0;
    end else begin
      // Address leads data by one cycle, so the high byte is asked for early
      if (in_reset) vector_addr <= fetch_start ? VEC_HI_ADDR : VEC_LO_ADDR;
      if (state == ST_VEC_LO) program_counter[7:0] <= vector_data;
      if (state == ST_VEC_HI) program_counter[15:8] <= vector_data;
      pc_valid <= (next_state == ST_RUN) && (state != ST_HOLD);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_drive_en <= 1'b0;
      cpu_run       <= 1'b0;
      wdt_cause     <= 1'b0;
    end else begin
      pins_drive_en <= (state == ST_RUN) && !reset_in;
      cpu_run       <= (next_state == ST_RUN) && !cpu_stopped && !stop_entry;
      if (reset_in) wdt_cause <= wdt_overflow && pin_n_sync;
    end
  end

  // STOP survives the hold phase and ends when the wait begins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_stopped <= 1'b0;
      se0_at_stop <= 1'b0;
    end else if (state == ST_HOLD) begin
      if (!reset_in) cpu_stopped <= 1'b0;
    end else if (stop_entry) begin
      cpu_stopped <= 1'b1;
      se0_at_stop <= usb_se0;
    end else if (cpu_stopped && wake) begin
      cpu_stopped <= 1'b0;
      se0_at_stop <= 1'b0;
    end
  end

  // Reset values held throughout hold and wait; USB flag set beats clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regs <= REG_INIT;
    end else if (in_reset) begin
      regs <= REG_INIT;
    end else begin
      if (wr_fire && w_lane && idx_rw(aw_idx) && aw_idx != IDX_CMP)
        regs[aw_idx] <= w_byte;
      if (usb_reset_resume_irq)
        regs[IDX_IRQ_REQ][USB_RR_BIT] <= 1'b1;
    end
  end

  // Left without reset: software must initialise it before use
  always_ff @(posedge core_clk) begin
    if (!in_reset && wr_fire && w_lane && aw_idx == IDX_CMP)
      cmp_reg <= w_byte;
  end

  assign port_out_latch = regs[IDX_PORT];
  assign port_direction = regs[IDX_DIR];

  // AXI4-Lite write: address and data captured independently
  assign awready = !aw_held;
  assign wready  = !w_held;
  assign arready = !rvalid;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= '0;
      w_byte  <= '0;
      w_lane  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_idx  <= awaddr[ADDR_W-1:2];
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= idx_ok(aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, rd_byte};
      rresp  <= idx_ok(ar_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic [STAB_W:0] wait_len;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)                wait_len <= '0;
    else if (state != ST_WAIT) wait_len <= '0;
    else                       wait_len <= wait_len + 1'b1;
  end

  wdt_reset_a: assert property (
    wdt_overflow |=> state == ST_HOLD && !pins_drive_en)
    else $error("watchdog overflow did not reset");

  pin_reset_a: assert property (
    !pin_n_sync |=> state == ST_HOLD ##1 !pc_valid)
    else $error("reset pin did not reset");

  logic [7:0] vector_data_q;
  logic [7:0] vector_lo_q;
  always_ff @(posedge core_clk) begin
    vector_data_q <= vector_data;
    if (state == ST_VEC_LO) vector_lo_q <= vector_data;
  end

  vector_fetch_a: assert property (
    state == ST_VEC_HI && !reset_in |=> state == ST_RUN &&
      program_counter == {vector_data_q, vector_lo_q})
    else $error("program counter not loaded from vector");

  vec_addr_a: assert property (
    state == ST_VEC_LO |-> vector_addr == VEC_HI_ADDR)
    else $error("high vector byte not requested in time");

  pins_float_a: assert property (
    (state != ST_RUN) |=> !pins_drive_en)
    else $error("pins driven during reset or wait");

  stab_length_a: assert property (
    (state == ST_WAIT && next_state == ST_VEC_LO) |->
      wait_len == (STAB_W+1)'(STAB_CYCLES - 1))
    else $error("stabilization wait has wrong length");

  wdt_release_a: assert property (
    (wdt_overflow && pin_n_sync) ##1 !reset_in |=> state == ST_WAIT)
    else $error("watchdog reset did not release itself");

  stop_hold_a: assert property (
    (state == ST_HOLD && cpu_stopped && reset_in) |=> cpu_stopped && !pins_drive_en)
    else $error("STOP lost during reset input");

  pc_undef_a: assert property (
    in_reset |=> !pc_valid && !cpu_run)
    else $error("program counter valid during reset");

  psw_init_a: assert property (
    state == ST_WAIT |=> regs[IDX_PSW] == 8'h02 && port_direction == 8'hff)
    else $error("reset values not applied");

  se0_block_a: assert property (
    (cpu_stopped && se0_at_stop && !ext_wake && state != ST_HOLD && !reset_in)
      |=> cpu_stopped)
    else $error("USB wake ended STOP entered in SE0");

  usb_wake_a: assert property (
    (cpu_stopped && usb_reset_resume_irq && !usb_mask && !se0_at_stop &&
      state == ST_RUN && !reset_in) |=> !cpu_stopped)
    else $error("USB wake did not end STOP");

  stop_entry_a: assert property (
    (stop_entry && usb_se0) |=> cpu_stopped && se0_at_stop)
    else $error("STOP entry in SE0 not marked");

  drive_release_a: assert property (
    (state == ST_RUN && !reset_in) |=> pins_drive_en)
    else $error("pins not driven after start");

  port_init_a: assert property (
    state == ST_WAIT |=> port_out_latch == 8'h00 &&
      regs[IDX_PULLUP] == 8'h00 && regs[IDX_OUTMODE] == 8'h00)
    else $error("port reset values not applied");

  clock_init_a: assert property (
    state == ST_WAIT |=> regs[IDX_PCC] == 8'h02 && regs[IDX_OSTS] == 8'h04)
    else $error("clock reset values not applied");

  mask_init_a: assert property (
    state == ST_WAIT |=> regs[IDX_IRQ_MASK] == 8'hff && regs[IDX_IRQ_REQ] == 8'h00)
    else $error("interrupt reset values not applied");

  run_cover_c:   cover property (state == ST_VEC_HI ##1 state == ST_RUN);
  wdt_cover_c:   cover property (state == ST_RUN ##1 wdt_overflow);
  stop_cover_c:  cover property (cpu_stopped && se0_at_stop ##1 usb_reset_resume_irq);
  reset_stop_c:  cover property (cpu_stopped ##1 state == ST_HOLD);
endmodule
`default_nettype wire

// File: design/mcu_reset_pkg.sv
// Constants, register map and state encoding of the reset controller.
// Shared by the controller and its synchroniser; no surroundings assumed.
package mcu_reset_pkg;
  localparam int          REG_W        = 8;
  localparam int          NREG         = 27;
  localparam int          ADDR_W       = 7;
  // Register indices; byte address is four times the index
  localparam logic [4:0]  IDX_PSW      = 5'h00;
  localparam logic [4:0]  IDX_PORT     = 5'h01;
  localparam logic [4:0]  IDX_DIR      = 5'h02;
  localparam logic [4:0]  IDX_PULLUP   = 5'h03;
  localparam logic [4:0]  IDX_OUTMODE  = 5'h04;
  localparam logic [4:0]  IDX_PCC      = 5'h05;
  localparam logic [4:0]  IDX_OSTS     = 5'h06;
  localparam logic [4:0]  IDX_IRQ_REQ  = 5'h0d;
  localparam logic [4:0]  IDX_IRQ_MASK = 5'h0e;
  localparam logic [4:0]  IDX_CMP      = 5'h1b;
  localparam logic [4:0]  IDX_STAT     = 5'h1c;
  localparam int          USB_RR_BIT   = 0;
  // Values taken on reset, in index order 0x00..0x1a
  localparam logic [7:0]  REG_INIT [NREG] = '{
    8'h02, 8'h00, 8'hff, 8'h00, 8'h00, 8'h02, 8'h04,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hff, 8'h00, 8'h00,
    8'h18, 8'h20, 8'h30, 8'h01, 8'h08,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Reset vector bytes
  localparam logic [15:0] VEC_LO_ADDR  = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR  = 16'h0001;
  // Stabilization wait, in system clock periods
  localparam int          STAB_EXP     = 15;
  localparam int          STAB_CYCLES_DEF = 1 << STAB_EXP;
  localparam int          STAB_W       = 16;
  // Status register fields
  localparam int          ST_STATE_LSB = 0;
  localparam int          ST_WDT_BIT   = 3;
  localparam int          ST_STOP_BIT  = 4;
  localparam int          ST_SE0_BIT   = 5;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  typedef enum logic [2:0] {
    ST_HOLD   = 3'b000,
    ST_WAIT   = 3'b001,
    ST_VEC_LO = 3'b010,
    ST_VEC_HI = 3'b011,
    ST_RUN    = 3'b100
  } rst_state_t;
endpackage
